/* verilog/dofcs_pkg.sv */
// Purpose: Shared constants for the output, fault, clear and ramp controller
// Assumes: 10 MHz system clock, 16-bit output code
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave
package dofcs_pkg;

  localparam int CODE_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DATA = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_OUTPUT = 5'h0C;
  localparam logic [4:0] OFS_RESET = 5'h10;

  // Control register fields
  localparam int CTRL_CLR_LEVEL = 15;
  localparam int CTRL_RANGE_EXT = 14;
  localparam int CTRL_EXT_RES = 13;
  localparam int CTRL_OUT_EN = 12;
  localparam int CTRL_RATE_HI = 11;
  localparam int CTRL_RATE_LO = 8;
  localparam int CTRL_INC_HI = 7;
  localparam int CTRL_INC_LO = 5;
  localparam int CTRL_RAMP_EN = 4;
  localparam int CTRL_CHAIN = 3;
  localparam int CTRL_RANGE_HI = 2;
  localparam int CTRL_RANGE_LO = 0;
  localparam int CTRL_CURRENT_BIT = 2;
  localparam int CTRL_BIPOLAR_BIT = 1;

  // Status register fields
  localparam int STAT_LOOP_FAULT = 6;
  localparam int STAT_RAMPING = 5;
  localparam int STAT_OVER_TEMP = 4;

  localparam int RESET_BIT = 0;

  localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CTRL_RST = 16'h0000;

  // Ramp update frequency in Hz for each rate code
  localparam int RATE_HZ [16] = '{100000, 500000, 333333, 250000, 200000, 100000,
                                  50000, 33333, 25000, 20000, 12500, 10000,
                                  8333, 6666, 5000, 3921};
  localparam int DIV_W = 12;

endpackage

/* verilog/dofcs_tick_if.sv */
// Purpose: Carries the ramp tick request and answer between modules
// Assumes: One clock domain
// Notes: Controller drives rate and restart, divider returns tick
`timescale 1ns/1ps
`default_nettype none
interface dofcs_tick_if;
  logic [3:0] rate_code;
  logic restart;
  logic tick;
  modport ctrl (output rate_code, output restart, input tick);
  modport divider (input rate_code, input restart, output tick);
endinterface
`default_nettype wire

/* verilog/dofcs_sync2.sv */
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are static levels from outside the clock domain
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module dofcs_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dofcs_sync_t;

  dofcs_sync_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = d_in;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q_out = s_reg.sync;
endmodule
`default_nettype wire

/* verilog/dofcs_tick_div.sv */
// Purpose: Divides the system clock into ramp update ticks
// Assumes: Divisors fit DIV_W bits at the package clock rate
// Notes: Restart reloads the count so the first tick is a full period away
`timescale 1ns/1ps
`default_nettype none
module dofcs_tick_div
  import dofcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  dofcs_tick_if.divider tk
);
  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } dofcs_div_t;

  dofcs_div_t s_reg, s_next;
  logic [DIV_W-1:0] div_tab [16];

  for (genvar g = 0; g < 16; g++) begin : g_div
    if (CLK_HZ / RATE_HZ[g] >= (1 << DIV_W) || CLK_HZ / RATE_HZ[g] < 1) begin : g_bad
      $error("ramp divisor does not fit the counter");
    end
    assign div_tab[g] = DIV_W'(CLK_HZ / RATE_HZ[g]);
  end

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (tk.restart) begin
      s_next.count = '0;
    end else if (s_reg.count >= div_tab[tk.rate_code] - DIV_W'(1)) begin
      s_next.count = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.count = s_reg.count + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tk.tick = s_reg.tick;
endmodule
`default_nettype wire

/* verilog/dofcs_ctrl.sv */
// Purpose: Output control: fault alert, clear, range options and ramp engine
// Assumes: Avalon-MM slave with waitrequest, 10 MHz clock, pins synchronised
// Notes: Zero code everywhere after reset, output code held until rewritten
`timescale 1ns/1ps
`default_nettype none
module dofcs_ctrl
  import dofcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic clear_in,
  input wire logic clear_level_pin_in,
  input wire logic loop_compliance_in,
  input wire logic over_temp_in,
  output logic fault_alert_out,
  output logic fault_alert_oe_n_out,
  output logic [CODE_W-1:0] dac_code_out,
  output logic output_drive_enable_out,
  output logic external_resistor_select_out,
  output logic range_extend_out,
  output logic chain_mode_enable_out,
  output logic [2:0] range_select_field_out,
  output logic ramp_active_out
);
  typedef struct packed {
    logic [15:0] ctrl;
    logic [CODE_W-1:0] target;
    logic [CODE_W-1:0] out_code;
    logic ramping;
    logic restart;
    logic clear_prev;
    logic ack;
    logic [31:0] rdata;
    logic fault_oe_n;
    logic loop_flag;
    logic temp_flag;
  } dofcs_state_t;

  localparam dofcs_state_t STATE_RST = '{
    ctrl: CTRL_RST, target: CODE_ZERO, out_code: CODE_ZERO, ramping: 1'b0,
    restart: 1'b0, clear_prev: 1'b0, ack: 1'b0, rdata: 32'h0000_0000,
    fault_oe_n: 1'b1, loop_flag: 1'b0, temp_flag: 1'b0};

  dofcs_state_t s_reg, s_next;
  logic [3:0] pins_raw, pins_s;
  logic clear_s, clr_pin_s, loop_s, temp_s;

  dofcs_tick_if tk ();

  assign pins_raw = {clear_in, clear_level_pin_in, loop_compliance_in, over_temp_in};
  assign {clear_s, clr_pin_s, loop_s, temp_s} = pins_s;

  dofcs_sync2 #(.W(4)) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  dofcs_tick_div u_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .tk(tk)
  );

  assign tk.rate_code = s_reg.ctrl[CTRL_RATE_HI:CTRL_RATE_LO];
  assign tk.restart = s_reg.restart;

  // Write merge with byte enables on the low 16 bits
  function automatic logic [15:0] merge16(logic [15:0] old_v, logic [31:0] wd,
                                          logic [3:0] be);
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // Clear code from range and effective level
  function automatic logic [CODE_W-1:0] clear_code(logic [15:0] c, logic pin_lvl);
    logic lvl;
    lvl = pin_lvl | c[CTRL_CLR_LEVEL];
    if (c[CTRL_CURRENT_BIT]) begin
      return CODE_ZERO;
    end else if (c[CTRL_BIPOLAR_BIT]) begin
      return lvl ? CODE_ZERO : CODE_MID;
    end else begin
      return lvl ? CODE_MID : CODE_ZERO;
    end
  endfunction

  logic req;
  logic [CODE_W-1:0] step;
  logic [CODE_W-1:0] gap;
  logic [CODE_W-1:0] tgt;
  logic [CODE_W-1:0] outv;
  logic ramp_en;

  assign req = avs_read_in | avs_write_in;

  always_comb begin
    s_next = s_reg;
    tgt = s_reg.target;
    outv = s_reg.out_code;
    gap = '0;
    step = CODE_W'(1) << s_reg.ctrl[CTRL_INC_HI:CTRL_INC_LO];
    s_next.ack = 1'b0;
    s_next.clear_prev = clear_s;

    // Fault flags and alert pin
    s_next.loop_flag = loop_s;
    s_next.temp_flag = temp_s;
    s_next.fault_oe_n = ~(loop_s | temp_s);

    // Bus access: one wait cycle; writes land on the edge that ends the cycle after the wait
    if (req && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.rdata = '0;
      if (avs_read_in) begin
        if (avs_address_in == OFS_CTRL) begin
          s_next.rdata[15:0] = s_reg.ctrl;
        end else if (avs_address_in == OFS_DATA) begin
          s_next.rdata[CODE_W-1:0] = s_reg.target;
        end else if (avs_address_in == OFS_STATUS) begin
          s_next.rdata[STAT_LOOP_FAULT] = s_reg.loop_flag;
          s_next.rdata[STAT_RAMPING] = s_reg.ramping;
          s_next.rdata[STAT_OVER_TEMP] = s_reg.temp_flag;
        end else if (avs_address_in == OFS_OUTPUT) begin
          s_next.rdata[CODE_W-1:0] = s_reg.out_code;
        end else begin
          s_next.rdata = '0;
        end
      end
    end else if (avs_write_in && s_reg.ack) begin
      if (avs_address_in == OFS_CTRL) begin
        s_next.ctrl = merge16(s_reg.ctrl, avs_writedata_in, avs_byteenable_in);
        tgt = s_reg.out_code;
      end else if (avs_address_in == OFS_DATA) begin
        tgt = merge16(s_reg.target, avs_writedata_in, avs_byteenable_in);
      end else if (avs_address_in == OFS_RESET) begin
        if (avs_byteenable_in[0] && avs_writedata_in[RESET_BIT]) begin
          s_next.ctrl = CTRL_RST;
          tgt = CODE_ZERO;
          outv = CODE_ZERO;
        end
      end else begin
        s_next.ctrl = s_reg.ctrl;
      end
    end

    // Clear overrides the target while held; the value persists afterwards
    if (clear_s) begin
      tgt = clear_code(s_next.ctrl, clr_pin_s);
    end

    ramp_en = s_next.ctrl[CTRL_RAMP_EN];
    if (!ramp_en) begin
      outv = tgt;
    end else if (tk.tick && !s_reg.restart && outv != tgt) begin
      // One step per tick, clamped on the last one
      if (outv < tgt) begin
        gap = tgt - outv;
        outv = (gap <= step) ? tgt : outv + step;
      end else begin
        gap = outv - tgt;
        outv = (gap <= step) ? tgt : outv - step;
      end
    end

    s_next.restart = (tgt != s_reg.target);
    s_next.target = tgt;
    s_next.out_code = outv;
    s_next.ramping = ramp_en && (outv != tgt);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata_out = s_reg.rdata;
  assign avs_waitrequest_out = ~s_reg.ack;
  assign fault_alert_out = 1'b0 & s_reg.fault_oe_n;
  assign fault_alert_oe_n_out = s_reg.fault_oe_n;
  assign dac_code_out = s_reg.out_code;
  assign output_drive_enable_out = s_reg.ctrl[CTRL_OUT_EN];
  assign external_resistor_select_out = s_reg.ctrl[CTRL_EXT_RES];
  assign range_extend_out = s_reg.ctrl[CTRL_RANGE_EXT];
  assign chain_mode_enable_out = s_reg.ctrl[CTRL_CHAIN];
  assign range_select_field_out = s_reg.ctrl[CTRL_RANGE_HI:CTRL_RANGE_LO];
  assign ramp_active_out = s_reg.ramping;
endmodule
`default_nettype wire

/* test/dofcs_ctrl_asserts.sv */
// Purpose: Port checks for the output controller
// Assumes: One clock, async low reset
// Notes: Fault pins show three edges late
`timescale 1ns/1ps
`default_nettype none
module dofcs_ctrl_asserts
  import dofcs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic clear_in,
  input wire logic loop_compliance_in,
  input wire logic over_temp_in,
  input wire logic fault_alert_out,
  input wire logic fault_alert_oe_n_out,
  input wire logic [CODE_W-1:0] dac_code_out,
  input wire logic [2:0] range_select_field_out,
  input wire logic ramp_active_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  alert_data_a:
    assert property (fault_alert_out == 1'b0) else $error("alert data high");
  alert_idle_a:
    assert property ($past(reset_n_in, 3) && !$past(loop_compliance_in, 3)
      && !$past(over_temp_in, 3) |-> fault_alert_oe_n_out) else $error("alert idle");
  loop_alert_a:
    assert property ($past(reset_n_in, 3) && $past(loop_compliance_in, 3)
      |-> !fault_alert_oe_n_out) else $error("loop alert");
  temp_alert_a:
    assert property ($past(reset_n_in, 3) && $past(over_temp_in, 3)
      |-> !fault_alert_oe_n_out) else $error("temp alert");
  bus_answer_a:
    assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("bus answer");
  clear_bottom_a:
    assert property (clear_in && $past(clear_in, 4) && range_select_field_out[2]
      && !ramp_active_out |-> dac_code_out == 16'h0000) else $error("current clear");
  one_step_a:
    assert property (ramp_active_out && $past(ramp_active_out) && $changed(dac_code_out)
      |=> $stable(dac_code_out) [*8]) else $error("ramp step early");
  step_size_a:
    assert property ($past(ramp_active_out) && $changed(dac_code_out)
      |-> (dac_code_out - $past(dac_code_out)) <= 16'h0080
      || ($past(dac_code_out) - dac_code_out) <= 16'h0080) else $error("ramp step size");
endmodule
bind dofcs_ctrl dofcs_ctrl_asserts u_asserts (
  .clk_in(clk_in),
  .reset_n_in(reset_n_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .clear_in(clear_in),
  .loop_compliance_in(loop_compliance_in),
  .over_temp_in(over_temp_in),
  .fault_alert_out(fault_alert_out),
  .fault_alert_oe_n_out(fault_alert_oe_n_out),
  .dac_code_out(dac_code_out),
  .range_select_field_out(range_select_field_out),
  .ramp_active_out(ramp_active_out)
);
`default_nettype wire

/* test/dofcs_host_model.sv */
// Purpose: Host side of the register bus
// Assumes: Requests start after a rising edge
// Notes: Write data inverted once released
`timescale 1ns/1ps
`default_nettype none
module dofcs_host_model (
  input wire logic clk_in,
  input wire logic [31:0] avs_readdata_in,
  input wire logic avs_waitrequest_in,
  output logic [4:0] avs_address_out,
  output logic avs_read_out,
  output logic avs_write_out,
  output logic [31:0] avs_writedata_out,
  output logic [3:0] avs_byteenable_out
);
  initial begin
    avs_address_out = 5'h00;
    avs_read_out = 1'b0;
    avs_write_out = 1'b0;
    avs_writedata_out = 32'h0000_0000;
    avs_byteenable_out = 4'hF;
  end
  task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d,
      output logic [15:0] r);
    @(posedge clk_in);
    avs_address_out <= a;
    avs_read_out <= !w;
    avs_write_out <= w;
    avs_writedata_out <= {16'h0000, d};
    @(posedge clk_in);
    while (avs_waitrequest_in !== 1'b0) @(posedge clk_in);
    r = avs_readdata_in[15:0];
    avs_read_out <= 1'b0;
    avs_write_out <= 1'b0;
    avs_writedata_out <= {16'hFFFF, ~d};
  endtask
endmodule
`default_nettype wire

/* test/dac_output_fault_clear_slew_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the output controller
// Assumes: Host model on the bus, bench drives the pins
// Notes: Ramp timing judged at falling edges
`timescale 1ns/1ps
`default_nettype none
module dac_output_fault_clear_slew_ctrl_tb_top
  import dofcs_pkg::*;
;
  logic clk_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, clear_in;
  logic clear_level_pin_in, loop_compliance_in, over_temp_in, fault_alert_out;
  logic fault_alert_oe_n_out, output_drive_enable_out, external_resistor_select_out;
  logic range_extend_out, chain_mode_enable_out, ramp_active_out;
  logic [4:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic [15:0] dac_code_out, q;
  logic [2:0] range_select_field_out;
  int miscompares, check_count, n;
  dofcs_ctrl DUT (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .clear_in(clear_in),
    .clear_level_pin_in(clear_level_pin_in),
    .loop_compliance_in(loop_compliance_in),
    .over_temp_in(over_temp_in),
    .fault_alert_out(fault_alert_out),
    .fault_alert_oe_n_out(fault_alert_oe_n_out),
    .dac_code_out(dac_code_out),
    .output_drive_enable_out(output_drive_enable_out),
    .external_resistor_select_out(external_resistor_select_out),
    .range_extend_out(range_extend_out),
    .chain_mode_enable_out(chain_mode_enable_out),
    .range_select_field_out(range_select_field_out),
    .ramp_active_out(ramp_active_out)
  );
  dofcs_host_model host (.clk_in(clk_in), .avs_readdata_in(avs_readdata_out),
    .avs_waitrequest_in(avs_waitrequest_out), .avs_address_out(avs_address_in),
    .avs_read_out(avs_read_in), .avs_write_out(avs_write_in),
    .avs_writedata_out(avs_writedata_in), .avs_byteenable_out(avs_byteenable_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.access(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [4:0] a);
    host.access(a, 1'b0, 16'h0000, q);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_in);
  endtask
  task automatic until_move(input logic [15:0] v);
    n = 0;
    while (dac_code_out === v && n < 6000) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic regs_case();
    wr(OFS_CTRL, 16'h700D);
    cyc(2);
    chk(16'({range_extend_out, external_resistor_select_out}), 16'h0003);
    chk(16'({output_drive_enable_out, chain_mode_enable_out}), 16'h0003);
    chk(16'(range_select_field_out), 16'h0005);
    rd(OFS_CTRL);
    chk(q, 16'h700D);
    wr(OFS_STATUS, 16'hFFFF);
    rd(OFS_STATUS);
    chk(q, 16'h0000);
    rd(5'h14);
    chk(q, 16'h0000);
    wr(OFS_DATA, 16'h5A5A);
    rd(OFS_DATA);
    chk(q, 16'h5A5A);
    rd(OFS_OUTPUT);
    chk(q, 16'h5A5A);
    wr(OFS_RESET, 16'h0001);
    rd(OFS_CTRL);
    chk(q, 16'h0000);
    rd(OFS_OUTPUT);
    chk(q, 16'h0000);
  endtask
  task automatic fault_case();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in) {over_temp_in, loop_compliance_in} <= 2'(1 << i);
      cyc(5);
      chk(16'(fault_alert_oe_n_out), 16'h0000);
      rd(OFS_STATUS);
      chk(q, (i == 0) ? 16'h0040 : 16'h0010);
    end
    @(posedge clk_in) over_temp_in <= 1'b0;
    cyc(5);
    chk(16'({fault_alert_oe_n_out, fault_alert_out}), 16'h0002);
  endtask
  task automatic clear_case();
    logic [35:0] t [6] = '{36'h0000_0_0000, 36'h0000_1_8000, 36'h8000_0_8000,
      36'h0002_0_8000, 36'h8002_0_0000, 36'h8005_1_0000};
    foreach (t[i]) begin
      wr(OFS_CTRL, t[i][35:20]);
      @(posedge clk_in) clear_level_pin_in <= t[i][16];
      wr(OFS_DATA, 16'h1234);
      cyc(2);
      chk(dac_code_out, 16'h1234);
      @(posedge clk_in) clear_in <= 1'b1;
      cyc(6);
      chk(dac_code_out, t[i][15:0]);
      @(posedge clk_in) clear_in <= 1'b0;
      cyc(10);
      chk(dac_code_out, t[i][15:0]);
    end
    @(posedge clk_in) clear_level_pin_in <= 1'b0;
  endtask
  task automatic ramp_case();
    logic [15:0] b;
    logic [15:0] e;
    b = 16'h0000;
    for (int r = 0; r < 16; r++) begin
      wr(OFS_CTRL, {4'h0, 4'(r), 8'hF0});
      wr(OFS_DATA, b + 16'h0120);
      rd(OFS_STATUS);
      chk(q, 16'h0020);
      e = b;
      for (int i = 0; i < 3; i++) begin
        until_move(e);
        e = (i == 2) ? b + 16'h0120 : e + 16'h0080;
        chk(dac_code_out, e);
        if (i > 0) chk(16'(n), 16'(CLK_HZ / RATE_HZ[r]));
      end
      chk(16'(ramp_active_out), 16'h0000);
      b = e;
    end
  endtask
  task automatic halt_case();
    wr(OFS_CTRL, 16'h0010);
    wr(OFS_DATA, 16'h1300);
    cyc(350);
    wr(OFS_CTRL, 16'h0010);
    cyc(250);
    chk(dac_code_out, 16'h1203);
    chk(16'(ramp_active_out), 16'h0000);
    wr(OFS_CTRL, 16'h01F0);
    @(posedge clk_in) clear_in <= 1'b1;
    cyc(8);
    chk(dac_code_out, 16'h1203);
    chk(16'(ramp_active_out), 16'h0001);
    n = 0;
    while (ramp_active_out !== 1'b0 && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
    chk(dac_code_out, 16'h0000);
    @(posedge clk_in) clear_in <= 1'b0;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #6000000;
    miscompares++;
    close_out();
  end
  initial begin
    reset_n_in = 1'b0;
    clear_in = 1'b0;
    clear_level_pin_in = 1'b0;
    loop_compliance_in = 1'b0;
    over_temp_in = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    regs_case();
    fault_case();
    clear_case();
    ramp_case();
    halt_case();
    close_out();
  end
endmodule
`default_nettype wire
